//--- hw/dcp_pkg.sv
package dcp_pkg;

    // ==========================================================
    // register map, byte addresses
    // ==========================================================
    localparam int         ADDR_W    = 8;         // bus address width
    localparam logic [7:0] CTRL_OFS  = 8'h00;     // crc_control_reg
    localparam logic [7:0] VALUE_OFS = 8'h04;     // crc_value_reg
    localparam logic [7:0] TAP_OFS   = 8'h08;     // crc_tap_mask_reg
    localparam logic [7:0] CH_BASE   = 8'h10;     // first channel pair
    localparam int         CH_SHIFT  = 3;         // 8 bytes per channel

    // ==========================================================
    // field layout of crc_control_reg
    // ==========================================================
    localparam int TYPE_BIT = 15;                 // checksum_type_select
    localparam int POLYNOMIAL_LENGTH_W   = 5;                  // polynomial_length

    // ==========================================================
    // reset values and answers
    // ==========================================================
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK  = 2'h0;      // okay
    localparam logic [1:0]  RESP_ERR = 2'h2;      // slave error

    // ==========================================================
    // carriers from the channel engine
    // ==========================================================
    // one data item for the crc unit
    typedef struct packed {
        logic        valid;   // item present this cycle
        logic [15:0] data;    // byte in [7:0], or ip word
    } dcp_feed_t;

    // per-channel progress events
    typedef struct packed {
        logic       start;    // transfer start, clear both
        logic [2:0] src_step; // bytes read this cycle
        logic [2:0] dst_step; // bytes written this cycle
        logic       pat_mode; // pattern detect mode on
        logic       pat_hit;  // pattern detected this cycle
    } dcp_chan_evt_t;

endpackage : dcp_pkg

//--- hw/dcp_crc_unit.sv
// What this block does
// (R1) writing value register seeds the generator
// (R2) reading value returns live result, no effect
// (R3) lfsr mode: bits above length read zero
// (R4) ip mode: upper sixteen bits read zero
// (R5) ip mode: ones' complement write and read
// (R6) ip mode ignores the tap mask
// (R7) set tap bit feeds xor into stage
// (R8) clear tap bit shifts straight through
// (R9) source pointer sixteen bits, upper bits zero
// (R10) pattern detect clears the source pointer
// (R11) destination pointer sixteen bits, upper zero
// (R12) destination pointer counts bytes, wraps at ffff
// (R13) stages above length held at zero
// (R14) pointers advance by bytes moved
//
// The address map and register access over AXI4-Lite were decided locally.
module dcp_crc_unit #(
    parameter int NUM_CH = 4
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output wire logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output wire logic                  s_axi_wready,
    output wire logic [1:0]            s_axi_bresp,
    output wire logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output wire logic                  s_axi_arready,
    output wire logic [31:0]           s_axi_rdata,
    output wire logic [1:0]            s_axi_rresp,
    output wire logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire dcp_pkg::dcp_feed_t    crc_feed,
    input  wire dcp_pkg::dcp_chan_evt_t [NUM_CH-1:0] chan_evt
);

    // ==========================================================
    // state
    // ==========================================================
    // whole block state in one word
    typedef struct packed {
        logic                    aw_hold;  // address held
        logic [7:0]              aw_addr;  // held address
        logic                    w_hold;   // data held
        logic [31:0]             w_data;   // held data
        logic [3:0]              w_strb;   // held strobes
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    ip_mode;  // checksum_type_select
        logic [4:0]              polynomial_length;     // polynomial_length
        logic [31:0]             crc;      // generator state
        logic [31:0]             tap;      // tap mask
        logic [NUM_CH-1:0][15:0] src;      // src_progress_field
        logic [NUM_CH-1:0][15:0] dst;      // dst_progress_field
    } dcp_st_t;

    dcp_st_t     st_ff;      // registered state
    dcp_st_t     nxt_st;     // next state
    logic        aw_fire;    // address handshake
    logic        w_fire;     // data handshake
    logic        ar_fire;    // read handshake
    logic        wr_go;      // write performed now
    logic [31:0] cur_mask;   // live length mask
    logic [31:0] seed_img;   // seed as it will be held
    logic [31:0] ctl_new;    // control word after a write
    logic [32:0] rd_res;     // read mux, top bit unmapped

    // ==========================================================
    // helpers
    // ==========================================================
    // mask of the stages in use
    function automatic logic [31:0] len_mask(input logic [4:0] pl);
        return 32'hFFFF_FFFF >> (5'd31 - pl);
    endfunction : len_mask

    // one byte through the lfsr, msb first
    function automatic logic [31:0] lfsr_byte(
        input logic [31:0] c,
        input logic [31:0] t,
        input logic [4:0]  pl,
        input logic [7:0]  d
    );
        logic [31:0] v;
        logic        fb;
        logic [31:0] m;
        v = c;
        m = len_mask(pl);
        for (int b = 7; b >= 0; b--) begin
            // feedback from the top stage in use
            fb = v[pl] ^ d[b];
            // tapped stages xor, others just shift
            v = ((v << 1) ^ ({32{fb}} & t)) & m; // R7 R8 R13
        end
        return v;
    endfunction : lfsr_byte

    // fold a word into the complemented checksum
    function automatic logic [15:0] ip_add(
        input logic [15:0] c,
        input logic [15:0] w
    );
        logic [16:0] s;
        s = {1'b0, ~c} + {1'b0, w};
        return ~(s[15:0] + {15'h0000, s[16]}); // R5
    endfunction : ip_add

    // byte-lane merge under strobes
    function automatic logic [31:0] merge(
        input logic [31:0] o,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        logic [31:0] v;
        v = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction : merge

    // address falls on a channel pointer
    function automatic logic chan_ok(input logic [7:0] a);
        logic [7:0] r;
        r = a - dcp_pkg::CH_BASE;
        return a >= dcp_pkg::CH_BASE && a[1:0] == 2'h0
            && int'(r[7:dcp_pkg::CH_SHIFT]) < NUM_CH;
    endfunction : chan_ok

    // read mux, top bit flags unmapped
    function automatic logic [32:0] rd_word(
        input logic [7:0] a,
        input dcp_st_t    s
    );
        logic [7:0]  r;
        logic [32:0] o;
        r = a - dcp_pkg::CH_BASE;
        o = {1'b1, dcp_pkg::RST_WORD};
        if (a == dcp_pkg::CTRL_OFS) begin
            o = {17'h0_0000, s.ip_mode, 10'h000, s.polynomial_length};
        end else if (a == dcp_pkg::VALUE_OFS) begin
            // live result, reading changes nothing
            o = {1'b0, s.crc}; // R2
        end else if (a == dcp_pkg::TAP_OFS) begin
            o = {1'b0, s.tap};
        end else if (chan_ok(a)) begin
            // pointers in low half, upper half zero
            o = {17'h0_0000, r[2] ? s.dst[r[7:dcp_pkg::CH_SHIFT]]
                                  : s.src[r[7:dcp_pkg::CH_SHIFT]]}; // R9 R11
        end
        return o;
    endfunction : rd_word

    // ==========================================================
    // handshakes
    // ==========================================================
    assign aw_fire  = s_axi_awvalid && st_ff.awready;
    assign w_fire   = s_axi_wvalid && st_ff.wready;
    assign ar_fire  = s_axi_arvalid && st_ff.arready;
    assign wr_go    = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
    assign cur_mask = len_mask(st_ff.polynomial_length);

    // seed image for a plain full write
    assign seed_img = st_ff.ip_mode
                    ? {16'h0000, st_ff.w_data[15:0]}
                    : st_ff.w_data & cur_mask;

    // control word with the held data merged under strobes
    assign ctl_new = merge({16'h0000, st_ff.ip_mode, 10'h000, st_ff.polynomial_length},
                           st_ff.w_data, st_ff.w_strb);
    // read answer for the presented address
    assign rd_res  = rd_word(s_axi_araddr, st_ff);

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        nxt_st = st_ff;
        // catch address and data in either order
        if (aw_fire) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (w_fire) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        // data item from the channel engine
        if (crc_feed.valid) begin
            if (st_ff.ip_mode) begin
                // tap mask not consulted here
                nxt_st.crc = {16'h0000, ip_add(st_ff.crc[15:0],
                                               crc_feed.data)}; // R5 R6
            end else begin
                nxt_st.crc = lfsr_byte(st_ff.crc, st_ff.tap,
                                       st_ff.polynomial_length,
                                       crc_feed.data[7:0]); // R7 R8
            end
        end
        // channel pointers
        for (int c = 0; c < NUM_CH; c++) begin
            if (chan_evt[c].start) begin
                nxt_st.src[c] = 16'h0000;
                nxt_st.dst[c] = 16'h0000;
            end else begin
                if (chan_evt[c].pat_mode && chan_evt[c].pat_hit) begin
                    nxt_st.src[c] = 16'h0000; // R10
                end else begin
                    nxt_st.src[c] = st_ff.src[c]
                                  + 16'(chan_evt[c].src_step); // R14
                end
                // byte count, wraps past byte 65535
                nxt_st.dst[c] = st_ff.dst[c]
                              + 16'(chan_evt[c].dst_step); // R12 R14
            end
        end
        // perform a held write, seed wins over data
        if (wr_go) begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = dcp_pkg::RESP_OK;
            if (st_ff.aw_addr == dcp_pkg::CTRL_OFS) begin
                nxt_st.ip_mode = ctl_new[dcp_pkg::TYPE_BIT];
                nxt_st.polynomial_length    = ctl_new[dcp_pkg::POLYNOMIAL_LENGTH_W-1:0];
            end else if (st_ff.aw_addr == dcp_pkg::VALUE_OFS) begin
                // new seed, held already in result form
                nxt_st.crc = merge(st_ff.crc, st_ff.w_data,
                                   st_ff.w_strb); // R1 R5
            end else if (st_ff.aw_addr == dcp_pkg::TAP_OFS) begin
                nxt_st.tap = merge(st_ff.tap, st_ff.w_data,
                                   st_ff.w_strb);
            end else if (!chan_ok(st_ff.aw_addr)) begin
                // unmapped address: slave error; pointer writes dropped with okay
                nxt_st.bresp = dcp_pkg::RESP_ERR;
            end
        end else if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // hold unused stages and bits at zero
        if (nxt_st.ip_mode) begin
            nxt_st.crc[31:16] = 16'h0000; // R4
        end else begin
            nxt_st.crc = nxt_st.crc & len_mask(nxt_st.polynomial_length); // R3 R13
        end
        // one write under way at a time
        nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_hold && !nxt_st.bvalid;
        // read answer
        if (ar_fire) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_res[31:0];
            nxt_st.rresp  = rd_res[32]
                          ? dcp_pkg::RESP_ERR : dcp_pkg::RESP_OK;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.arready = !nxt_st.rvalid;
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // bus outputs straight from the state
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rvalid  = st_ff.rvalid;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // full write of the value register seeds it
    property p_seed;
        wr_go && st_ff.aw_addr == dcp_pkg::VALUE_OFS
            && st_ff.w_strb == 4'hF
        |=> st_ff.crc == $past(seed_img);
    endproperty
    a_seed: assert property (p_seed) // R1
        else $error("seed not loaded");

    // read of value returns the live result
    property p_rd;
        ar_fire && s_axi_araddr == dcp_pkg::VALUE_OFS
        |=> s_axi_rvalid && s_axi_rdata == $past(st_ff.crc);
    endproperty
    a_rd: assert property (p_rd) // R2
        else $error("value read wrong");

    // reads leave the generator alone
    property p_rd_keep;
        ar_fire && !wr_go && !crc_feed.valid |=> $stable(st_ff.crc);
    endproperty
    a_rd_keep: assert property (p_rd_keep) // R2
        else $error("read disturbed crc");

    // bits above the length stay zero
    property p_len;
        !st_ff.ip_mode |-> (st_ff.crc & ~cur_mask) == 32'h0000_0000;
    endproperty
    a_len: assert property (p_len) // R3
        else $error("bits above length set");

    // ip mode upper half zero
    property p_ip_hi;
        st_ff.ip_mode |-> st_ff.crc[31:16] == 16'h0000;
    endproperty
    a_ip_hi: assert property (p_ip_hi) // R4
        else $error("ip upper half set");

    // ip word folds in ones' complement
    property p_ip_sum;
        st_ff.ip_mode && crc_feed.valid && !wr_go
        |=> st_ff.crc[15:0] == ip_add($past(st_ff.crc[15:0]),
                                      $past(crc_feed.data));
    endproperty
    a_ip_sum: assert property (p_ip_sum) // R5
        else $error("ip checksum wrong");

    // lfsr byte uses the tap mask
    property p_lfsr;
        !st_ff.ip_mode && crc_feed.valid && !wr_go
        |=> st_ff.crc == lfsr_byte($past(st_ff.crc), $past(st_ff.tap),
                                   $past(st_ff.polynomial_length),
                                   $past(crc_feed.data[7:0]));
    endproperty
    a_lfsr: assert property (p_lfsr) // R7
        else $error("lfsr step wrong");

    // pointer reads have zero upper half
    property p_ptr_hi;
        ar_fire && chan_ok(s_axi_araddr)
        |=> s_axi_rdata[31:16] == 16'h0000 && s_axi_rresp == 2'h0;
    endproperty
    a_ptr_hi: assert property (p_ptr_hi) // R9
        else $error("pointer read wrong");

    // per channel: pattern clear and destination count
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        // pattern hit clears source pointer
        property p_pat;
            @(posedge aclk) disable iff (!aresetn)
            chan_evt[g].pat_mode && chan_evt[g].pat_hit
            |=> st_ff.src[g] == 16'h0000;
        endproperty
        a_pat: assert property (p_pat) // R10
            else $error("pattern did not clear");

        // destination counts bytes and wraps
        property p_dst;
            @(posedge aclk) disable iff (!aresetn)
            !chan_evt[g].start
            |=> st_ff.dst[g] == 16'($past(st_ff.dst[g])
                                   + 16'($past(chan_evt[g].dst_step)));
        endproperty
        a_dst: assert property (p_dst) // R12
            else $error("destination count wrong");
    end

endmodule : dcp_crc_unit

//--- testbench/dcp_engine_model.sv
// ==========
// channel engine model: crc feed and pointer events
module dcp_engine_model #(
    parameter int NUM_CH = 4
) (
    input  wire logic                           aclk,
    output dcp_pkg::dcp_feed_t                  crc_feed,
    output dcp_pkg::dcp_chan_evt_t [NUM_CH-1:0] chan_evt
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle feed and no events at time zero
    initial begin
        crc_feed = '0;
        chan_evt = '0;
    end

    // one item for one cycle, then data flips so stale data is unusable
    task send(input logic [15:0] w);
        @(posedge aclk);
        crc_feed <= '{valid: 1'h1, data: w};
        @(posedge aclk);
        crc_feed <= '{valid: 1'h0, data: ~w};
    endtask : send

    // hold one event word on a channel for n edges
    task run(input int ch, input logic st, input logic [2:0] s,
             input logic [2:0] d, input logic pm, input logic ph,
             input int n);
        dcp_pkg::dcp_chan_evt_t e;
        e = '{st, s, d, pm, ph};
        @(posedge aclk);
        chan_evt[ch] <= e;
        repeat (n) @(posedge aclk);
        chan_evt[ch] <= '0;
    endtask : run
endmodule : dcp_engine_model

//--- testbench/dcp_crc_unit_tb.sv
// ==========
// bench for the crc unit and channel pointers
module dcp_crc_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         NCH = 4;
    localparam logic [1:0] OK  = dcp_pkg::RESP_OK;
    localparam logic [1:0] ERR = dcp_pkg::RESP_ERR;
    localparam logic [7:0] CTL = dcp_pkg::CTRL_OFS;
    localparam logic [7:0] VAL = dcp_pkg::VALUE_OFS;
    localparam logic [7:0] TAP = dcp_pkg::TAP_OFS;
    localparam logic [7:0] S1  = dcp_pkg::CH_BASE + 8'h08; // ch1 source
    localparam logic [7:0] D1  = dcp_pkg::CH_BASE + 8'h0C; // ch1 dest
    localparam logic [7:0] D3  = dcp_pkg::CH_BASE + 8'h1C; // ch3 dest
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [3:0]  s_axi_wstrb;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic   s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    dcp_pkg::dcp_feed_t                  crc_feed;
    dcp_pkg::dcp_chan_evt_t [NCH-1:0]    chan_evt;
    int          errors, checks;
    logic [31:0] e;                      // expected crc
    logic [15:0] v;                      // expected checksum
    logic [4:0]  c_len [3] = '{5'h07, 5'h0F, 5'h1F};
    logic [31:0] c_tap [3] = '{32'h0000_0007, 32'h0000_1021, 32'h04C1_1DB7};
    logic [31:0] c_sd  [3] = '{32'hFFFF_FF5A, 32'h8000_FFFF, 32'hFFFF_FFFF};
    logic [7:0]  bt    [3] = '{8'hC3, 8'h3C, 8'h01};
    logic [15:0] ipw   [3] = '{16'h4500, 16'hFFFF, 16'hB1E6};

    dcp_crc_unit #(.NUM_CH(NCH)) dcp_crc_unit_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .crc_feed(crc_feed),
        .chan_evt(chan_evt));
    dcp_engine_model #(.NUM_CH(NCH)) engine_inst (
        .aclk(aclk), .crc_feed(crc_feed), .chan_evt(chan_evt));

    // ==========
    // clock, 50 ns period
    always #25 aclk = ~aclk;

    // ==========
    // reference models
    function automatic logic [31:0] len_mask(input logic [4:0] pl);
        return 32'hFFFF_FFFF >> (5'h1F - pl);
    endfunction : len_mask

    // msb first, feedback from top active stage
    function automatic logic [31:0] lfsr_ref(input logic [31:0] c,
        input logic [31:0] t, input logic [4:0] pl, input logic [7:0] d);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[pl] ^ d[i];
            c = ((c << 1) ^ (fb ? t : 32'h0000_0000)) & len_mask(pl);
        end
        return c;
    endfunction : lfsr_ref

    // held value is the complemented running sum
    function automatic logic [15:0] ip_ref(input logic [15:0] o,
                                           input logic [15:0] w);
        logic [16:0] s;
        s = {1'h0, ~o} + {1'h0, w};
        s = {1'h0, s[15:0]} + {16'h0000, s[16]};
        return ~s[15:0];
    endfunction : ip_ref

    // ==========
    // compare and bus tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // write: aw and w together, bready held until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'h1, er});
    endtask : wr

    // read: compare data and response at the rvalid edge
    task rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ex);
        chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'h1, er});
    endtask : rd

    // verdict and end of run
    task final_report;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ==========
    // watchdog, well past the expected run
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    // ==========
    // main sequence
    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        errors = 0;
        checks = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        // reset values
        rd(CTL, 32'h0000_0000, OK);
        rd(TAP, 32'h0000_0000, OK);
        rd(S1, 32'h0000_0000, OK);
        // seed and side-effect-free reads, full length
        wr(CTL, 32'h0000_001F, OK);
        wr(VAL, 32'h1234_5678, OK);
        rd(VAL, 32'h1234_5678, OK);
        rd(VAL, 32'h1234_5678, OK);
        // partial strobes replace only the lanes given
        s_axi_wstrb <= 4'h3;
        wr(VAL, 32'hAAAA_BBBB, OK);
        s_axi_wstrb <= 4'hF;
        rd(VAL, 32'h1234_BBBB, OK);
        // lfsr configurations: short, middle, full length
        for (int i = 0; i < 3; i++) begin
            wr(CTL, {27'h0, c_len[i]}, OK);
            wr(TAP, c_tap[i], OK);
            rd(TAP, c_tap[i], OK);
            wr(VAL, c_sd[i], OK);
            e = c_sd[i] & len_mask(c_len[i]);
            rd(VAL, e, OK);
            for (int b = 0; b < 3; b++) begin
                engine_inst.send({8'hEE, bt[b]});
                e = lfsr_ref(e, c_tap[i], c_len[i], bt[b]);
                rd(VAL, e, OK);
            end
        end
        // checksum mode with a full tap mask, then a cleared one
        wr(TAP, 32'hFFFF_FFFF, OK);
        wr(CTL, 32'h0000_8000, OK);
        wr(VAL, 32'hABCD_1234, OK);
        rd(VAL, 32'h0000_1234, OK);
        v = 16'h1234;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(TAP, 32'h0000_0000, OK);
            engine_inst.send(ipw[i]);
            v = ip_ref(v, ipw[i]);
            rd(VAL, {16'h0000, v}, OK);
        end
        // unmapped, misaligned and read-only places
        wr(8'hF0, 32'h1111_1111, ERR);
        rd(8'hF0, 32'h0000_0000, ERR);
        rd(8'h12, 32'h0000_0000, ERR);
        wr(S1, 32'hFFFF_FFFF, OK);
        rd(S1, 32'h0000_0000, OK);
        // pointers advance by bytes moved
        engine_inst.run(1, 1'h0, 3'h4, 3'h2, 1'h0, 1'h0, 10);
        rd(S1, 32'h0000_0028, OK);
        rd(D1, 32'h0000_0014, OK);
        // pattern detect clears source only
        engine_inst.run(1, 1'h0, 3'h3, 3'h1, 1'h1, 1'h1, 1);
        rd(S1, 32'h0000_0000, OK);
        rd(D1, 32'h0000_0015, OK);
        // hit without pattern mode leaves source counting
        engine_inst.run(1, 1'h0, 3'h3, 3'h1, 1'h0, 1'h1, 2);
        rd(S1, 32'h0000_0006, OK);
        rd(D1, 32'h0000_0017, OK);
        engine_inst.run(1, 1'h1, 3'h0, 3'h0, 1'h0, 1'h0, 1);
        rd(D1, 32'h0000_0000, OK);
        // destination reaches the last byte, then wraps
        engine_inst.run(3, 1'h0, 3'h0, 3'h7, 1'h0, 1'h0, 9362);
        engine_inst.run(3, 1'h0, 3'h0, 3'h1, 1'h0, 1'h0, 1);
        rd(D3, 32'h0000_FFFF, OK);
        engine_inst.run(3, 1'h0, 3'h0, 3'h1, 1'h0, 1'h0, 1);
        rd(D3, 32'h0000_0000, OK);
        final_report();
    end
endmodule : dcp_crc_unit_tb
